// ===== logic/drt_cfg.svh
/*
 * Constants of the request routing and transfer sequencer: register offsets,
 * field positions, reset values and timing counts.
 * Assumes inclusion by bare name from the package and the design module.
 */
`ifndef DRT_CFG_SVH
`define DRT_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DRT_OFS_CTRL 8'h00
`define DRT_OFS_BYPASS 8'h04
`define DRT_OFS_FLYBY 8'h08
`define DRT_OFS_BLOCK 8'h0c
`define DRT_OFS_DEMAND 8'h10
`define DRT_OFS_DIR 8'h14
`define DRT_OFS_ARM 8'h18
`define DRT_OFS_COUNT 8'h1c
`define DRT_OFS_ADDR 8'h20
`define DRT_OFS_STATUS 8'h24

// ----------------------------------------------------------------
// Board control fields
// ----------------------------------------------------------------
`define DRT_CTRL_CH4_SEL 0
`define DRT_CTRL_T2_EN 1
`define DRT_CTRL_T3_EN 2
`define DRT_CTRL_T4_EN 3
`define DRT_CTRL_SCAN_EN 4
`define DRT_CTRL_RESET 8'h10

// ----------------------------------------------------------------
// Request lines driven by timer outputs, and the GPIB channel
// ----------------------------------------------------------------
`define DRT_T2_LINE 5
`define DRT_T3_LINE 0
`define DRT_T4_LINE 6
`define DRT_GPIB_CH 4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DRT_CLK_NS 20
`define DRT_SCAN_NS 160
`define DRT_SCAN_CYCLES ((`DRT_SCAN_NS + `DRT_CLK_NS - 1) / `DRT_CLK_NS)

`endif

// ===== logic/drt_pkg.sv
/*
 * Types of the request routing and transfer sequencer.
 * Assumes drt_cfg.svh is on the include path.
 */
package drt_pkg;
    `include "drt_cfg.svh"

    // Gray codes along idle, wait, fetch, deposit, flyby, release
    typedef enum logic [2:0] {
        DRT_IDLE = 3'h0,
        DRT_WAIT_GRANT = 3'h1,
        DRT_FETCH = 3'h3,
        DRT_DEPOSIT = 3'h2,
        DRT_FLYBY = 3'h6,
        DRT_RELEASE = 3'h4
    } drt_state_t;

    typedef struct packed {
        logic [7:0] req_s1;
        logic [7:0] req_s2;
        logic eop_s1;
        logic eop_s2;
        logic [7:0] scan_hold;
        logic [7:0] scan_cnt;
        logic [7:0] req_prev;
        logic [7:0] pending;
        logic [7:0] ctrl;
        logic [7:0] bypass;
        logic [7:0] flyby;
        logic [7:0] block;
        logic [7:0] demand;
        logic [7:0] dir;
        logic [7:0] enable;
        logic [7:0] done;
        logic [7:0][15:0] count;
        logic [7:0][15:0] addr;
        drt_state_t st;
        logic [2:0] ch;
        logic [31:0] data;
        logic eop_out;
        logic ack;
        logic [31:0] rdata;
    } drt_regs_t;
endpackage

// ===== logic/drt_router.sv
/*
 * Eight-channel request router and transfer sequencer with an Avalon-MM
 * register slave (one wait state per access).
 * Assumes a single 50 MHz clock, a local bus arbiter answering bus_request
 * with bus_grant, and a system bus answering each cycle with cycle_ack.
 */
`timescale 1ns/1ns
`include "drt_cfg.svh"

module drt_router
    import drt_pkg::*;
#(
    parameter int SCAN_DIV = `DRT_SCAN_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] trigger_bus_request_n_in,
    output logic [7:0] trigger_bus_request_n_out,
    output logic [7:0] trigger_bus_request_n_oe,
    input wire logic end_of_process_n,
    output logic end_of_process_out_n,
    input wire logic gpib_request,
    output logic gpib_select,
    input wire logic timer_output_two,
    input wire logic timer_output_three,
    input wire logic timer_output_four,
    output logic [7:0] controller_request_in,
    output logic bus_request,
    input wire logic bus_grant,
    output logic cycle_valid,
    output logic cycle_write,
    output logic cycle_on_target,
    output logic [15:0] cycle_addr,
    output logic [31:0] cycle_wdata,
    input wire logic [31:0] cycle_rdata,
    input wire logic cycle_ack,
    output logic [2:0] external_ack_lines,
    output logic external_ack_valid
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
            input logic [31:0] new_v, input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [3:0] lowest_set(input logic [7:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_s1;
    logic rst_sync_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1 <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_sync_n <= rst_s1;
        end
    end

    drt_regs_t r;
    drt_regs_t next_r;
    logic [7:0] raw_req;
    logic [7:0] service;
    logic [3:0] pick;
    logic [31:0] wr_word;
    logic last_xfer;
    logic finish;
    logic acc;

    // ----------------------------------------------------------------
    // Request routing
    // ----------------------------------------------------------------
    always_comb begin
        raw_req = ~r.req_s2;
        controller_request_in = 8'h00;
        for (int i = 0; i < 8; i++) begin
            controller_request_in[i] = r.bypass[i] ? raw_req[i] : r.scan_hold[i];
        end
        controller_request_in[`DRT_GPIB_CH] = r.ctrl[`DRT_CTRL_CH4_SEL] ? gpib_request
            : (r.bypass[0] ? raw_req[0] : r.scan_hold[0]);
        gpib_select = r.ctrl[`DRT_CTRL_CH4_SEL];
        trigger_bus_request_n_out = 8'h00;
        trigger_bus_request_n_oe = 8'h00;
        trigger_bus_request_n_oe[`DRT_T2_LINE] = r.ctrl[`DRT_CTRL_T2_EN] & timer_output_two;
        trigger_bus_request_n_oe[`DRT_T3_LINE] = r.ctrl[`DRT_CTRL_T3_EN] & timer_output_three;
        trigger_bus_request_n_oe[`DRT_T4_LINE] = r.ctrl[`DRT_CTRL_T4_EN] & timer_output_four;
        service = r.enable & (controller_request_in | r.pending);
        pick = lowest_set(service);
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always_comb begin
        bus_request = (r.st == DRT_WAIT_GRANT) || (r.st == DRT_FETCH)
            || (r.st == DRT_DEPOSIT) || (r.st == DRT_FLYBY);
        cycle_valid = (r.st == DRT_FETCH) || (r.st == DRT_DEPOSIT) || (r.st == DRT_FLYBY);
        cycle_write = (r.st == DRT_DEPOSIT) || ((r.st == DRT_FLYBY) && r.dir[r.ch]);
        cycle_on_target = ((r.st == DRT_FETCH) && !r.dir[r.ch])
            || ((r.st == DRT_DEPOSIT) && r.dir[r.ch]) || (r.st == DRT_FLYBY);
        cycle_addr = r.addr[r.ch];
        cycle_wdata = (r.st == DRT_DEPOSIT) ? r.data : 32'h0000_0000;
        external_ack_valid = (r.st == DRT_FLYBY);
        external_ack_lines = external_ack_valid ? r.ch : 3'h0;
        end_of_process_out_n = ~r.eop_out;
        avs_waitrequest = (avs_read | avs_write) & ~r.ack;
        avs_readdata = r.rdata;
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_r = r;
        acc = (avs_read | avs_write) & ~r.ack;
        wr_word = 32'h0000_0000;
        last_xfer = (r.count[r.ch] <= 16'h0001) || !r.eop_s2;
        finish = 1'b0;
        next_r.req_s1 = trigger_bus_request_n_in;
        next_r.req_s2 = r.req_s1;
        next_r.eop_s1 = end_of_process_n;
        next_r.eop_s2 = r.eop_s1;
        // Scan path samples on a divided tick; disabling it drops scanned requests
        next_r.scan_cnt = (r.scan_cnt >= 8'(SCAN_DIV - 1)) ? 8'h00 : r.scan_cnt + 8'h01;
        if (r.scan_cnt == 8'h00) begin
            next_r.scan_hold = r.ctrl[`DRT_CTRL_SCAN_EN] ? raw_req : 8'h00;
        end
        // a pulse is remembered until served
        next_r.req_prev = controller_request_in;
        next_r.eop_out = 1'b0;
        next_r.ack = acc;
        case (r.st)
            DRT_IDLE: begin
                if (pick[3]) begin
                    next_r.ch = pick[2:0];
                    next_r.st = DRT_WAIT_GRANT;
                end
            end
            DRT_WAIT_GRANT: begin
                if (bus_grant) begin
                    next_r.pending[r.ch] = 1'b0;
                    // mode from flyby and block bits
                    next_r.st = (r.flyby[r.ch] && !r.block[r.ch]) ? DRT_FLYBY : DRT_FETCH;
                end
            end
            DRT_FETCH: begin
                if (cycle_ack) begin
                    next_r.data = cycle_rdata;
                    next_r.st = DRT_DEPOSIT;
                end
            end
            DRT_DEPOSIT: finish = cycle_ack;
            DRT_FLYBY: finish = cycle_ack;
            default: next_r.st = DRT_IDLE;
        endcase
        if (finish) begin
            next_r.count[r.ch] = r.count[r.ch] - 16'h0001;
            next_r.addr[r.ch] = r.addr[r.ch] + 16'h0001;
            if (last_xfer) begin
                // count expiry or end-of-process ends the channel
                next_r.enable[r.ch] = 1'b0;
                next_r.done[r.ch] = 1'b1;
                next_r.eop_out = 1'b1;
                next_r.st = DRT_RELEASE;
            end else if (r.demand[r.ch] && controller_request_in[r.ch]) begin
                // keep the bus back to back
                next_r.pending[r.ch] = 1'b0;
                next_r.st = (r.st == DRT_FLYBY) ? DRT_FLYBY : DRT_FETCH;
            end else begin
                // give the bus up, resume later in place
                next_r.st = DRT_RELEASE;
            end
        end else if (r.st == DRT_RELEASE) begin
            next_r.st = DRT_IDLE;
        end
        // Register writes land on the acknowledging edge
        if (avs_write && r.ack) begin
            wr_word = merge_lanes(32'h0000_0000, avs_writedata, avs_byteenable);
            if (avs_address == `DRT_OFS_CTRL) begin
                next_r.ctrl = avs_byteenable[0] ? wr_word[7:0] : r.ctrl;
            end else if (avs_address == `DRT_OFS_BYPASS) begin
                next_r.bypass = avs_byteenable[0] ? wr_word[7:0] : r.bypass;
            end else if (avs_address == `DRT_OFS_FLYBY) begin
                next_r.flyby = avs_byteenable[0] ? wr_word[7:0] : r.flyby;
            end else if (avs_address == `DRT_OFS_BLOCK) begin
                next_r.block = avs_byteenable[0] ? wr_word[7:0] : r.block;
            end else if (avs_address == `DRT_OFS_DEMAND) begin
                next_r.demand = avs_byteenable[0] ? wr_word[7:0] : r.demand;
            end else if (avs_address == `DRT_OFS_DIR) begin
                next_r.dir = avs_byteenable[0] ? wr_word[7:0] : r.dir;
            end else if (avs_address == `DRT_OFS_ARM) begin
                // Done bits set by a finishing transfer win over this clear
                next_r.enable = (next_r.enable | wr_word[7:0]) & ~wr_word[15:8];
                next_r.done = r.done & ~wr_word[7:0] | (next_r.done & ~r.done);
            end else if (avs_address == `DRT_OFS_COUNT) begin
                next_r.count[wr_word[18:16]] = wr_word[15:0];
            end else if (avs_address == `DRT_OFS_ADDR) begin
                next_r.addr[wr_word[18:16]] = wr_word[15:0];
            end
        end
        // per-channel pulse memory, set wins over clear
        next_r.pending = next_r.pending | (controller_request_in & ~r.req_prev);
        if (avs_read && !r.ack) begin
            if (avs_address == `DRT_OFS_CTRL) begin
                next_r.rdata = {24'h0, r.ctrl};
            end else if (avs_address == `DRT_OFS_BYPASS) begin
                next_r.rdata = {24'h0, r.bypass};
            end else if (avs_address == `DRT_OFS_FLYBY) begin
                next_r.rdata = {24'h0, r.flyby};
            end else if (avs_address == `DRT_OFS_BLOCK) begin
                next_r.rdata = {24'h0, r.block};
            end else if (avs_address == `DRT_OFS_DEMAND) begin
                next_r.rdata = {24'h0, r.demand};
            end else if (avs_address == `DRT_OFS_DIR) begin
                next_r.rdata = {24'h0, r.dir};
            end else if (avs_address == `DRT_OFS_ARM) begin
                next_r.rdata = {16'h0, r.done, r.enable};
            end else if (avs_address == `DRT_OFS_COUNT) begin
                next_r.rdata = {13'h0, r.ch, r.count[r.ch]};
            end else if (avs_address == `DRT_OFS_ADDR) begin
                next_r.rdata = {13'h0, r.ch, r.addr[r.ch]};
            end else if (avs_address == `DRT_OFS_STATUS) begin
                next_r.rdata = {16'h0, controller_request_in, 2'h0, r.st, r.ch};
            end else begin
                next_r.rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            r <= '0;
            r.req_s1 <= 8'hff;
            r.req_s2 <= 8'hff;
            r.eop_s1 <= 1'b1;
            r.eop_s2 <= 1'b1;
            r.ctrl <= `DRT_CTRL_RESET;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync_n);

    sequence s_fetch_done;
        (r.st == DRT_FETCH) && cycle_ack;
    endsequence
    sequence s_deposit;
        (r.st == DRT_DEPOSIT) && cycle_write && !cycle_ack;
    endsequence

    a_fetch_then_deposit: assert property (s_fetch_done |=> s_deposit or (cycle_ack && cycle_write))
        else $error("fetch not followed by deposit write");
    a_bypass_path: assert property (r.bypass[7] |-> controller_request_in[7] == ~r.req_s2[7])
        else $error("bypass request not from inverted line");
    a_ch4_gpib: assert property (r.ctrl[0] |-> controller_request_in[4] == gpib_request)
        else $error("channel four not from gpib");
    a_timer_route: assert property (r.ctrl[1] && timer_output_two |-> trigger_bus_request_n_oe[5])
        else $error("timer two not driving line five");
    a_sync_delay: assert property (r.req_s2 == $past(trigger_bus_request_n_in, 2))
        else $error("request not two-stage synchronised");
    a_single_release: assert property (finish && !r.demand[r.ch] |=> r.st == DRT_RELEASE ##1 !bus_request)
        else $error("single transfer kept the bus");
    a_demand_keep: assert property (finish && !last_xfer && r.demand[r.ch]
            && controller_request_in[r.ch] |=> bus_request && cycle_valid)
        else $error("demand transfer dropped the bus");
    a_demand_pause: assert property (finish && r.demand[r.ch] && !controller_request_in[r.ch]
            |=> !bus_request)
        else $error("paused demand kept the bus");
    a_end_channel: assert property (finish && last_xfer |=> !r.enable[$past(r.ch)] && !end_of_process_out_n)
        else $error("channel not ended on terminal transfer");
    a_flyby_mode: assert property (r.st == DRT_WAIT_GRANT && bus_grant && r.flyby[r.ch] && !r.block[r.ch]
            |=> r.st == DRT_FLYBY)
        else $error("flyby channel not flyby");
    a_two_cycle_mode: assert property (r.st == DRT_WAIT_GRANT && bus_grant && !r.flyby[r.ch]
            |=> r.st == DRT_FETCH)
        else $error("two-cycle channel not fetching");
    a_flyby_ack: assert property (r.st == DRT_FLYBY |-> external_ack_valid
            && external_ack_lines == r.ch && cycle_wdata == 32'h0)
        else $error("flyby acknowledge wrong");
endmodule

// ===== tb/drt_requester.sv
/*
 * Model of a requesting board on the trigger bus.
 * Assumes the bench gives it the same clock as the router and wires the
 * open-drain request lines itself.
 */
`timescale 1ns/1ns
module drt_requester (
    input wire logic clk,
    input wire logic [7:0] hold,
    input wire logic end_now,
    input wire logic external_ack_valid,
    input wire logic cycle_ack,
    input wire logic cycle_write,
    input wire logic [31:0] cycle_rdata,
    output logic [7:0] trigger_bus_request_n = 8'hff,
    output logic end_of_process_n = 1'b1,
    output logic [31:0] captured = 32'h0
);
    always @(posedge clk) begin
        trigger_bus_request_n <= ~hold;
        end_of_process_n <= ~end_now;
        if (external_ack_valid && cycle_ack && !cycle_write) begin
            captured <= cycle_rdata;
        end
    end
endmodule

// ===== tb/tb_top.sv
/*
 * Self-checking bench of the request router and transfer sequencer.
 * Assumes the router, its package and the requester model are compiled first.
 */
`timescale 1ns/1ns
module tb_top;
    logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0] avs_address = 8'h0, hold = 8'h0, req_n;
    logic [31:0] avs_writedata = 32'h0, cycle_rdata = 32'h0, last_rd = 32'h0, d;
    logic gpib_request = 1'b0, t2 = 1'b0, t3 = 1'b0, t4 = 1'b0, end_now = 1'b0;
    logic bus_grant = 1'b0, cycle_ack = 1'b0, prev_breq = 1'b0, eop_n;
    logic [2:0] exp_ch = 3'h0;
    wire logic [31:0] avs_readdata, cycle_wdata;
    wire logic [7:0] tb_out, tb_oe, ctl_req;
    wire logic avs_waitrequest, eop_out_n, bus_request, cycle_valid, cycle_write;
    wire logic cycle_on_target, external_ack_valid;
    wire logic [15:0] cycle_addr;
    wire logic [2:0] external_ack_lines;
    wire logic [31:0] captured;
    wire logic [7:0] line_n = req_n & ~(tb_oe & ~tb_out);
    int err_total = 0, compares = 0, ticks = 0, n, n_fetch, n_dep, n_fly, n_rel, n_eop;

    drt_router #(.SCAN_DIV(2)) drt_router_inst (.clk(clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .trigger_bus_request_n_in(line_n),
        .trigger_bus_request_n_out(tb_out), .trigger_bus_request_n_oe(tb_oe),
        .end_of_process_n(eop_n), .end_of_process_out_n(eop_out_n),
        .gpib_request(gpib_request), .gpib_select(), .timer_output_two(t2),
        .timer_output_three(t3), .timer_output_four(t4), .controller_request_in(ctl_req),
        .bus_request(bus_request), .bus_grant(bus_grant), .cycle_valid(cycle_valid),
        .cycle_write(cycle_write), .cycle_on_target(cycle_on_target),
        .cycle_addr(cycle_addr), .cycle_wdata(cycle_wdata), .cycle_rdata(cycle_rdata),
        .cycle_ack(cycle_ack), .external_ack_lines(external_ack_lines),
        .external_ack_valid(external_ack_valid));

    drt_requester drt_requester_inst (.clk(clk), .hold(hold), .end_now(end_now),
        .external_ack_valid(external_ack_valid), .cycle_ack(cycle_ack),
        .cycle_write(cycle_write), .cycle_rdata(cycle_rdata),
        .trigger_bus_request_n(req_n), .end_of_process_n(eop_n), .captured(captured));

    initial forever #10 clk = ~clk;

    // ----------------------------------------------------------------
    // Local bus arbiter and system bus target, one wait state each
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        bus_grant <= bus_request;
        cycle_ack <= cycle_valid & ~cycle_ack;
        if (cycle_ack) begin
            cycle_rdata <= cycle_rdata + 32'h3;
        end
    end

    // Sampled mid-cycle so the design's edge updates have landed
    always @(negedge clk) begin
        prev_breq <= bus_request;
        if (prev_breq === 1'b1 && bus_request === 1'b0) n_rel++;
        if (eop_out_n === 1'b0) n_eop++;
        if (cycle_valid === 1'b1 && cycle_ack === 1'b1) begin
            if (external_ack_valid === 1'b1) begin
                n_fly++;
                chk("ack_lines", {29'h0, external_ack_lines}, {29'h0, exp_ch});
                if (cycle_write === 1'b0) last_rd = cycle_rdata;
            end else if (cycle_write === 1'b0) begin
                n_fetch++;
                chk("fetch_side", {31'h0, cycle_on_target}, 32'h1);
                last_rd = cycle_rdata;
            end else begin
                n_dep++;
                chk("deposit_data", cycle_wdata, last_rd);
            end
        end
        ticks++;
        if (ticks > 30000) begin
            err_total++;
            conclude();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Held until waitrequest is seen low, released after that edge
    task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] wd);
        avs_address <= a;
        avs_read <= rd;
        avs_write <= ~rd;
        avs_writedata <= wd;
        @(negedge clk);
        while (avs_waitrequest !== 1'b0) @(negedge clk);
        d = avs_readdata;
        @(posedge clk);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic setup(input logic [7:0] fly, dem, dir, arm, input logic [31:0] cnt);
        n_fetch = 0; n_dep = 0; n_fly = 0; n_rel = 0; n_eop = 0;
        bus(0, 8'h08, {24'h0, fly});
        bus(0, 8'h10, {24'h0, dem});
        bus(0, 8'h14, {24'h0, dir});
        bus(0, 8'h1c, cnt);
        bus(0, 8'h18, {24'h0, arm});
    endtask

    task automatic wait_done(input int ch);
        d = 32'h0;
        for (n = 0; n < 400 && d[8 + ch] !== 1'b1; n++) bus(1, 8'h18, 32'h0);
        chk("done_seen", {31'h0, d[8 + ch]}, 32'h1);
        hold <= 8'h0;
        repeat (6) @(posedge clk);
    endtask

    task automatic wait_dep(input int k);
        for (n = 0; n < 400 && n_dep < k; n++) @(posedge clk);
        chk("deposits_seen", {31'h0, n_dep >= k}, 32'h1);
    endtask

    task automatic settle(input logic [7:0] exp_oe, exp_req);
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk("request_oe", {24'h0, tb_oe}, {24'h0, exp_oe});
        chk("controller_req", {24'h0, ctl_req}, {24'h0, exp_req});
        @(posedge clk);
    endtask

    task automatic t_route();
        bus(0, 8'h30, 32'hff);
        bus(1, 8'h30, 32'h0);
        chk("unmapped", d, 32'h0);
        bus(0, 8'h04, 32'hff);
        hold <= 8'hee;
        settle(8'h00, 8'hee);
        hold <= 8'h00;
        gpib_request <= 1'b1;
        t2 <= 1'b1;
        bus(0, 8'h00, 32'h13);
        settle(8'h20, 8'h30);
        gpib_request <= 1'b0;
        {t2, t3, t4} <= 3'b011;
        bus(0, 8'h00, 32'h1c);
        settle(8'h41, 8'h51);
        {t3, t4} <= 2'b00;
        bus(0, 8'h00, 32'h10);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1, 8'h00, 32'h0);
        chk("ctrl_reset", d, 32'h10);
        t_route();
        exp_ch = 3'h0;
        setup(8'h00, 8'h00, 8'h00, 8'h01, 32'h2);
        hold <= 8'h01;
        wait_done(0);
        chk("fetches", n_fetch, 2);
        chk("releases", n_rel, 2);
        chk("eop_pulses", n_eop, 1);
        exp_ch = 3'h2;
        setup(8'h04, 8'h04, 8'h04, 8'h04, 32'h20003);
        hold <= 8'h04;
        wait_done(2);
        chk("flyby_cycles", n_fly, 3);
        chk("data_cycles", n_fetch + n_dep, 0);
        chk("releases", n_rel, 1);
        exp_ch = 3'h3;
        setup(8'h00, 8'h08, 8'h00, 8'h08, 32'h30004);
        hold <= 8'h08;
        wait_dep(1);
        hold <= 8'h00;
        repeat (20) @(posedge clk);
        chk("paused_bus", {31'h0, bus_request}, 32'h0);
        bus(1, 8'h18, 32'h0);
        chk("paused_done", {31'h0, d[11]}, 32'h0);
        hold <= 8'h08;
        wait_done(3);
        chk("resumed_total", n_dep, 4);
        exp_ch = 3'h1;
        setup(8'h00, 8'h02, 8'h00, 8'h02, 32'h10064);
        hold <= 8'h02;
        wait_dep(2);
        end_now <= 1'b1;
        repeat (4) @(posedge clk);
        end_now <= 1'b0;
        wait_done(1);
        chk("eop_cut", {31'h0, n_dep < 12}, 32'h1);
        chk("eop_pulses", n_eop, 1);
        // timer-made requests go through the scan path
        bus(0, 8'h04, 32'h0);
        bus(0, 8'h00, 32'h12);
        t2 <= 1'b1;
        exp_ch = 3'h5;
        setup(8'h20, 8'h00, 8'h00, 8'h20, 32'h50002);
        wait_done(5);
        t2 <= 1'b0;
        chk("flyby_single", n_fly, 2);
        chk("releases", n_rel, 2);
        chk("flyby_capture", captured, last_rd);
        conclude();
    end
endmodule
